/* rtl/rtw_pkg.sv */
// Purpose: constants and types of the read/write transponder controller
// Assumes: field clock domain runs all protocol timing
// Notes: block bits numbered 0 (lock) to 32, bit 1 sent first
package rtw_pkg;
	// ==========================================================
	// timing counts in field clocks, terminator length in bit periods
	localparam logic [12:0] INIT_FC = 13'h00C0;
	localparam int unsigned POR_DELAY_FC = 8190;
	localparam logic [6:0] ZERO_MIN = 7'h10;
	localparam logic [6:0] ZERO_MAX = 7'h1F;
	localparam logic [6:0] ONE_MIN = 7'h30;
	localparam logic [6:0] ONE_MAX = 7'h3F;
	localparam logic [6:0] RX_TIMEOUT = 7'h40;
	localparam logic [5:0] BIT_FC_LAST = 6'h3F;
	localparam logic [2:0] TERM_PERIODS = 3'h4;
	// ==========================================================
	// configuration block layout
	localparam int unsigned CFG_MKEY_LO = 1;
	localparam int unsigned CFG_XMODE = 15;
	localparam int unsigned CFG_MOD_LO = 16;
	localparam int unsigned CFG_PORDLY = 24;
	localparam int unsigned CFG_PWD = 28;
	localparam int unsigned CFG_ST = 29;
	localparam int unsigned CFG_LAST_READ_BLOCK_FIELD_LO = 30;
	localparam logic [3:0] MKEY_DENY = 4'h6;
	localparam logic [4:0] MOD_MANCH = 5'h08;
	localparam logic [31:0] CFG_RESET = 32'h00148000;
	localparam logic [32:0] TRACE_RESET = 33'h100000000;
	// ==========================================================
	// command layout
	localparam logic [1:0] OP_RESET = 2'h0;
	localparam logic [1:0] OP_TEST = 2'h1;
	localparam logic [6:0] N_PAGE = 7'h02;
	localparam logic [6:0] N_DIRECT = 7'h06;
	localparam logic [6:0] N_WRITE = 7'h26;
	localparam logic [6:0] N_PWD_WRITE = 7'h46;
	localparam logic [6:0] RX_MAX = 7'h46;
	// ==========================================================
	// types
	typedef enum logic [3:0] {
		S_INIT = 4'h1,
		S_DELAY = 4'h2,
		S_READ = 4'h4,
		S_RX = 4'h8
	} rtw_state_t;
	typedef struct packed {
		logic reading;
		logic block_mode;
		logic page;
	} rtw_stat_t;
endpackage

/* rtl/rtw_ctrl.sv */
// Purpose: transponder controller: init, read streams, command decode
// Assumes: fclk is the recovered field clock and keeps running in gaps
// Notes: clk side only sees synchronised status and a command event
`timescale 1ns/100ps
`default_nettype none
module rtw_ctrl #(
	parameter int unsigned POR_DELAY_FC = rtw_pkg::POR_DELAY_FC
) (
	// system side
	input wire logic clk,
	input wire logic arst_n,
	output var rtw_pkg::rtw_stat_t stat,
	output logic cmd_done,
	// field side
	input wire logic fclk,
	input wire logic gap_in,
	output logic mod_load,
	output logic rx_damp
);
	// ==========================================================
	// reset and gap synchronisers
	logic [1:0] frst_q;
	logic frst_n;
	logic [1:0] gap_q;
	logic gap_d;
	logic gap_rise;

	// reset release aligned to the field clock
	always_ff @(posedge fclk or negedge arst_n) begin
		if (!arst_n) begin
			frst_q <= 2'h0;
		end else begin
			frst_q <= {frst_q[0], 1'b1};
		end
	end
	assign frst_n = frst_q[1];

	// gap detector input crosses in through two flops
	always_ff @(posedge fclk or negedge frst_n) begin
		if (!frst_n) begin
			gap_q <= 2'h0;
			gap_d <= 1'b0;
		end else begin
			gap_q <= {gap_q[0], gap_in};
			gap_d <= gap_q[1];
		end
	end
	assign gap_rise = gap_q[1] & ~gap_d; // gap start

	// ==========================================================
	// memory and configuration
	logic [0:32] mem0 [0:7];
	logic [0:32] mem1 [1:2];
	logic [0:32] cfg;
	logic [2:0] last_read_block_field;
	logic pwd_en;
	logic st_en;
	logic manch;
	logic test_deny;

	assign last_read_block_field = cfg[rtw_pkg::CFG_LAST_READ_BLOCK_FIELD_LO +: 3];
	assign pwd_en = cfg[rtw_pkg::CFG_PWD];
	assign st_en = cfg[rtw_pkg::CFG_ST] & ~cfg[rtw_pkg::CFG_XMODE];
	assign manch = cfg[rtw_pkg::CFG_MOD_LO +: 5] == rtw_pkg::MOD_MANCH;
	assign test_deny = cfg[rtw_pkg::CFG_MKEY_LO +: 4] == rtw_pkg::MKEY_DENY;

	// ==========================================================
	// state and command registers
	rtw_pkg::rtw_state_t st;
	logic [12:0] init_cnt;
	logic block_mode;
	logic page;
	logic [2:0] sel_blk;
	logic cmd_tgl;
	logic [6:0] iv;
	logic [6:0] nbits;
	logic rx_err;
	logic [0:69] rx_bits;
	logic timeout;

	assign timeout = (st == rtw_pkg::S_RX) && (iv > rtw_pkg::RX_TIMEOUT);

	// ==========================================================
	// command evaluation at end of reception
	logic [1:0] opc;
	logic pw_ok;
	logic ex_reinit;
	logic ex_block;
	logic ex_page;
	logic [2:0] ex_addr;
	logic ex_prog;
	logic [0:32] ex_word;

	assign opc = rx_bits[0:1];
	assign pw_ok = rx_bits[2:33] == mem0[7][1:32];

	// decode opcode, bit count and password
	always_comb begin
		ex_reinit = 1'b0;
		ex_block = 1'b0;
		ex_page = page; // invalid keeps old page
		ex_addr = 3'h0;
		ex_prog = 1'b0;
		ex_word = 33'h0;
		if (!rx_err && nbits == rtw_pkg::N_PAGE) begin
			if (opc == rtw_pkg::OP_RESET) begin
				ex_reinit = 1'b1;
			end else if (opc[1]) begin
				ex_page = opc[0];
			end
		end else if (!rx_err && opc == rtw_pkg::OP_TEST && test_deny) begin
			ex_page = page; // test access ignored
		end else if (!rx_err && opc[1] && !pwd_en) begin
			if (nbits == rtw_pkg::N_DIRECT && !rx_bits[2]) begin
				ex_block = 1'b1;
				ex_page = opc[0];
				ex_addr = rx_bits[3:5];
			end else if (nbits == rtw_pkg::N_WRITE) begin
				ex_block = 1'b1;
				ex_page = opc[0];
				ex_addr = rx_bits[35:37];
				ex_word = rx_bits[2:34];
				ex_prog = 1'b1;
			end
		end else if (!rx_err && opc[1] && pw_ok) begin
			if (nbits == rtw_pkg::N_WRITE && !rx_bits[34]) begin
				ex_block = 1'b1;
				ex_page = opc[0];
				ex_addr = rx_bits[35:37];
			end else if (nbits == rtw_pkg::N_PWD_WRITE) begin
				ex_block = 1'b1;
				ex_page = opc[0];
				ex_addr = rx_bits[67:69];
				ex_word = rx_bits[34:66];
				ex_prog = 1'b1;
			end
		end
	end

	// ==========================================================
	// main sequencer
	always_ff @(posedge fclk or negedge frst_n) begin
		if (!frst_n) begin
			st <= rtw_pkg::S_INIT;
			init_cnt <= 13'h0000;
			cfg <= 33'h0;
			block_mode <= 1'b0;
			page <= 1'b0;
			sel_blk <= 3'h0;
			cmd_tgl <= 1'b0;
		end else begin
			unique case (st)
				rtw_pkg::S_INIT: begin
					if (gap_rise) begin
						init_cnt <= 13'h0000;
					end else if (init_cnt == rtw_pkg::INIT_FC - 13'h0001) begin
						cfg <= mem0[0];
						init_cnt <= 13'h0000;
						block_mode <= 1'b0;
						st <= mem0[0][rtw_pkg::CFG_PORDLY] ? rtw_pkg::S_DELAY
							: rtw_pkg::S_READ;
					end else begin
						init_cnt <= init_cnt + 13'h0001;
					end
				end
				rtw_pkg::S_DELAY: begin
					if (gap_rise) begin
						init_cnt <= 13'h0000;
						st <= rtw_pkg::S_INIT;
					end else if (init_cnt == 13'(POR_DELAY_FC - 1)) begin
						st <= rtw_pkg::S_READ;
					end else begin
						init_cnt <= init_cnt + 13'h0001;
					end
				end
				rtw_pkg::S_READ: begin
					if (gap_rise) begin
						st <= rtw_pkg::S_RX;
					end
				end
				rtw_pkg::S_RX: begin
					if (timeout) begin
						cmd_tgl <= ~cmd_tgl;
						st <= ex_reinit ? rtw_pkg::S_INIT : rtw_pkg::S_READ;
						block_mode <= ex_block;
						page <= ex_page;
						sel_blk <= ex_addr;
					end
				end
			endcase
		end
	end

	// programming: locked or page 1 blocks are left alone
	always_ff @(posedge fclk or negedge frst_n) begin
		if (!frst_n) begin
			mem0[0] <= {1'b0, rtw_pkg::CFG_RESET};
			for (int i = 1; i < 8; i++) begin
				mem0[i] <= 33'h0;
			end
			mem1[1] <= rtw_pkg::TRACE_RESET;
			mem1[2] <= rtw_pkg::TRACE_RESET;
		end else if (timeout && ex_prog && !ex_page && !mem0[ex_addr][0]) begin
			mem0[ex_addr] <= ex_word; // lock checked first
		end
	end

	// ==========================================================
	// reception: pulse interval decoding
	logic is_zero;
	logic is_one;

	assign is_zero = iv >= rtw_pkg::ZERO_MIN && iv <= rtw_pkg::ZERO_MAX;
	assign is_one = iv >= rtw_pkg::ONE_MIN && iv <= rtw_pkg::ONE_MAX;

	// interval counter, bit store and error flag
	always_ff @(posedge fclk or negedge frst_n) begin
		if (!frst_n) begin
			iv <= 7'h00;
			nbits <= 7'h00;
			rx_err <= 1'b0;
			rx_bits <= 70'h0;
		end else if (st == rtw_pkg::S_READ && gap_rise) begin
			iv <= 7'h00;
			nbits <= 7'h00;
			rx_err <= 1'b0;
		end else if (st == rtw_pkg::S_RX) begin
			if (gap_rise) begin
				iv <= 7'h00;
				if (!(is_zero || is_one) || nbits == rtw_pkg::RX_MAX) begin
					rx_err <= 1'b1;
				end else begin
					rx_bits[nbits] <= is_one;
					nbits <= nbits + 7'h01;
				end
			end else if (!timeout) begin
				iv <= iv + 7'h01;
			end
		end
	end

	// ==========================================================
	// transmit sequencing
	logic lead;
	logic [2:0] term;
	logic [5:0] tm;
	logic [5:0] bitn;
	logic [2:0] blk;
	logic [2:0] first_blk;
	logic [0:32] cur_word;
	logic tx_level;

	assign first_blk = block_mode ? sel_blk : ((last_read_block_field == 3'h0) ? 3'h0 : 3'h1);

	// word source for the block being sent
	always_comb begin
		cur_word = 33'h0; // page 1 blocks 3..7 read zero
		if (!page || blk == 3'h0) begin
			cur_word = mem0[blk]; // page 1 block 0 is config
		end else if (blk <= 3'h2) begin
			cur_word = mem1[blk[1:0] == 2'h1 ? 1 : 2];
		end
	end

	// bit periods: lead zero, terminator, then data
	always_ff @(posedge fclk or negedge frst_n) begin
		if (!frst_n) begin
			lead <= 1'b1;
			term <= 3'h0;
			tm <= 6'h00;
			bitn <= 6'h01;
			blk <= 3'h1;
		end else if (st != rtw_pkg::S_READ) begin
			lead <= 1'b1; // re-armed on every read entry
			term <= 3'h0;
			tm <= 6'h00;
			bitn <= 6'h01;
		end else if (tm != rtw_pkg::BIT_FC_LAST) begin
			tm <= tm + 6'h01;
		end else begin
			tm <= 6'h00;
			if (lead) begin
				lead <= 1'b0;
				blk <= first_blk;
				bitn <= 6'h01;
				term <= st_en ? rtw_pkg::TERM_PERIODS : 3'h0;
			end else if (term != 3'h0) begin
				term <= term - 3'h1;
			end else if (bitn != 6'h20) begin
				bitn <= bitn + 6'h01;
			end else begin
				bitn <= 6'h01;
				if (block_mode || last_read_block_field <= 3'h1 || blk >= last_read_block_field) begin
					blk <= first_blk; // wrap to start block
					term <= st_en ? rtw_pkg::TERM_PERIODS : 3'h0;
				end else begin
					blk <= blk + 3'h1;
				end
			end
		end
	end

	// line level: zero lead, terminator pattern, data bit
	always_comb begin
		if (lead) begin
			tx_level = 1'b0;
		end else if (term == 3'h3 || term == 3'h1) begin
			tx_level = manch; // second and fourth periods
		end else if (term != 3'h0) begin
			tx_level = 1'b1;
		end else begin
			tx_level = cur_word[bitn];
		end
	end

	// load and damping outputs
	always_ff @(posedge fclk or negedge frst_n) begin
		if (!frst_n) begin
			mod_load <= 1'b0;
			rx_damp <= 1'b0;
		end else begin
			mod_load <= (st == rtw_pkg::S_DELAY) || (st == rtw_pkg::S_READ && tx_level);
			rx_damp <= st == rtw_pkg::S_RX;
		end
	end

	// ==========================================================
	// crossing to the system clock
	rtw_pkg::rtw_stat_t stat_f;
	rtw_pkg::rtw_stat_t stat_s1;
	logic [2:0] tgl_s;

	// status levels in the field domain
	always_ff @(posedge fclk or negedge frst_n) begin
		if (!frst_n) begin
			stat_f <= '0;
		end else begin
			stat_f <= '{reading: st == rtw_pkg::S_READ, block_mode: block_mode, page: page};
		end
	end

	// two-flop level sync and toggle event sync
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stat_s1 <= '0;
			stat <= '0;
			tgl_s <= 3'h0;
			cmd_done <= 1'b0;
		end else begin
			stat_s1 <= stat_f;
			stat <= stat_s1;
			tgl_s <= {tgl_s[1:0], cmd_tgl};
			cmd_done <= tgl_s[1] ^ tgl_s[2];
		end
	end

	// ==========================================================
	// assertions
	init_len_a: assert property (@(posedge fclk) disable iff (!frst_n)
		(st == rtw_pkg::S_INIT && !gap_rise && init_cnt == rtw_pkg::INIT_FC - 13'h0001)
		|=> st != rtw_pkg::S_INIT && cfg == $past(mem0[0]))
		else $error("config not loaded at end of init");
	delay_damp_a: assert property (@(posedge fclk) disable iff (!frst_n)
		st == rtw_pkg::S_DELAY ##1 st == rtw_pkg::S_DELAY |-> mod_load)
		else $error("load not damped during delay");
	gap_restart_a: assert property (@(posedge fclk) disable iff (!frst_n)
		(st == rtw_pkg::S_INIT || st == rtw_pkg::S_DELAY) && gap_rise
		|=> st == rtw_pkg::S_INIT && init_cnt == 13'h0000)
		else $error("gap did not restart init");
	block_wrap_a: assert property (@(posedge fclk) disable iff (!frst_n)
		(st == rtw_pkg::S_READ && !lead && term == 3'h0 && bitn == 6'h20
		&& tm == rtw_pkg::BIT_FC_LAST && !block_mode && last_read_block_field > 3'h1 && blk == last_read_block_field)
		|=> blk == 3'h1 && bitn == 6'h01)
		else $error("regular read did not wrap to block 1");
	lead_zero_a: assert property (@(posedge fclk) disable iff (!frst_n)
		$rose(st == rtw_pkg::S_READ) |=> !mod_load [*8])
		else $error("first read bit not zero");
	rx_damp_a: assert property (@(posedge fclk) disable iff (!frst_n)
		st == rtw_pkg::S_RX |=> rx_damp)
		else $error("receive damping off in reception");
	bad_interval_a: assert property (@(posedge fclk) disable iff (!frst_n)
		(st == rtw_pkg::S_RX && gap_rise && iv > rtw_pkg::ZERO_MAX && iv < rtw_pkg::ONE_MIN)
		|=> rx_err)
		else $error("bad interval accepted");
	rx_end_a: assert property (@(posedge fclk) disable iff (!frst_n)
		(st == rtw_pkg::S_RX && !gap_rise) [*8] ##1 (st == rtw_pkg::S_RX && !gap_rise)
		[*8] ##0 (iv > rtw_pkg::RX_TIMEOUT) |=> st != rtw_pkg::S_RX)
		else $error("reception not ended after timeout");
	term_en_a: assert property (@(posedge fclk) disable iff (!frst_n)
		term != 3'h0 |-> st_en)
		else $error("terminator while disabled");
	bad_cmd_a: assert property (@(posedge fclk) disable iff (!frst_n)
		timeout && rx_err |=> st == rtw_pkg::S_READ && !block_mode && page == $past(page))
		else $error("invalid command changed page");
endmodule // rtw_ctrl
`default_nettype wire

/* testbench/rtw_reader.sv */
// Purpose: reader model sending gap coded commands to the tag
// Assumes: fclk runs through gaps; gap_in high while the field is off
// Notes: intervals counted from gap start to gap start in field clocks
`timescale 1ns/100ps
`default_nettype none
module rtw_reader (
	// field side
	input wire logic fclk,
	output logic gap_in
);
	// ==========================================================
	// gap sender
	initial begin
		gap_in = 1'h0;
	end
	// one gap of len clocks, then field on until ivl clocks from its start
	task automatic gap(input int len, input int ivl);
		gap_in <= 1'h1;
		repeat (len) @(posedge fclk);
		gap_in <= 1'h0;
		repeat (ivl - len) @(posedge fclk);
	endtask
	// start gap, one interval per bit msb first, closing gap; bad_at breaks one interval
	task automatic send(input logic [69:0] bits, input int n, input int bad_at);
		int i;
		int ivl;
		@(posedge fclk);
		for (i = 0; i < n; i++) begin
			ivl = (bits[n-1-i] === 1'h1) ? 54 : 24;
			if (i == bad_at) ivl = 40;
			gap((i == 0) ? 15 : 10, ivl);
		end
		gap(10, 10); // silence after this ends reception
	endtask
endmodule // rtw_reader
`default_nettype wire

/* testbench/rfid_tag_read_write_protocol_bench.sv */
// Purpose: self checking bench of the transponder controller
// Assumes: delay count shortened to 20 field clocks
// Notes: stream bits sampled mid period, 64 field clocks apart
`timescale 1ns/100ps
`default_nettype none
module rfid_tag_read_write_protocol_bench;
	localparam int DLY = 20;
	logic clk;
	logic fclk;
	logic arst_n;
	rtw_pkg::rtw_stat_t stat;
	logic cmd_done;
	logic mod_load;
	logic rx_damp;
	logic gap_in;
	int num_errors;
	int tests_run;
	int done_cnt;
	int d0;
	logic exp_q[$];
	logic [31:0] data;
	logic [31:0] cfg;
	logic [31:0] pw;
	// ==========================================================
	// design and reader
	rtw_ctrl #(.POR_DELAY_FC(DLY)) i_rtw_ctrl (.clk(clk), .arst_n(arst_n), .stat(stat),
		.cmd_done(cmd_done), .fclk(fclk), .gap_in(gap_in), .mod_load(mod_load), .rx_damp(rx_damp));
	rtw_reader i_rtw_reader (.fclk(fclk), .gap_in(gap_in));
	// clocks, unrelated in phase
	initial begin
		clk = 1'h0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		fclk = 1'h0;
		#3.1;
		forever #7.5 fclk = ~fclk;
	end
	// command end pulses
	always @(posedge clk) begin
		if (cmd_done === 1'h1) done_cnt++;
	end
	// ==========================================================
	// compare and report
	task automatic check_bit(input string name, input logic exp, input logic seen);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %b seen %b", name, exp, seen);
		end
	endtask
	task automatic check_vec(input string name, input logic [7:0] exp, input logic [7:0] seen);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ==========================================================
	// model of the stream: bit 1 of a block first
	task automatic push_word(input logic [31:0] w);
		for (int i = 31; i >= 0; i--) exp_q.push_back(w[i]);
	endtask
	task automatic push_term();
		exp_q.push_back(1'h1);
		exp_q.push_back(1'h0);
		exp_q.push_back(1'h1);
		exp_q.push_back(1'h0);
	endtask
	// wait to mid of first bit, then compare status and every queued bit
	task automatic check_stream(input int wait_fc, input logic [2:0] st);
		repeat (wait_fc) @(posedge fclk);
		check_vec("stat", {5'h00, st}, 8'(stat));
		check_bit("rx_damp idle", 1'h0, rx_damp);
		while (exp_q.size() > 0) begin
			check_bit("mod_load", exp_q.pop_front(), mod_load);
			repeat (64) @(posedge fclk);
		end
	endtask
	// send a command; damping must still stand right after the closing gap, before reception times out
	task automatic cmd(input logic [69:0] bits, input int n, input int bad);
		d0 = done_cnt;
		i_rtw_reader.send(bits, n, bad);
		check_bit("rx_damp", 1'h1, rx_damp);
	endtask
	// ==========================================================
	// watchdog
	initial begin
		repeat (100000) @(posedge clk);
		num_errors++;
		final_report();
	end
	// main sequence
	initial begin
		arst_n = 1'h0;
		num_errors = 0;
		tests_run = 0;
		done_cnt = 0;
		void'($urandom(57078));
		data = $urandom();
		cfg = 32'h00000109;
		repeat (20) @(posedge clk);
		arst_n <= 1'h1;
		// power up: lead zero, then config block cycles
		exp_q.push_back(1'h0);
		push_word(rtw_pkg::CFG_RESET);
		push_word(rtw_pkg::CFG_RESET);
		check_stream(226, 3'h4);
		// standard write of block 1, then block read of it
		cmd(70'({2'h2, 1'h0, data, 3'h1}), 38, -1);
		exp_q.push_back(1'h0);
		push_word(data);
		push_word(data);
		check_stream(90, 3'h6);
		check_vec("done", 8'(d0 + 1), 8'(done_cnt));
		// direct access page 1 block 0 reads config
		cmd(70'({2'h3, 1'h0, 3'h0}), 6, -1);
		exp_q.push_back(1'h0);
		push_word(rtw_pkg::CFG_RESET);
		check_stream(90, 3'h7);
		// direct access page 1 block 3 reads zeros
		cmd(70'({2'h3, 1'h0, 3'h3}), 6, -1);
		exp_q.push_back(1'h0);
		push_word(32'h00000000);
		check_stream(90, 3'h7);
		// broken interval: regular read on page 1
		cmd(70'({2'h3, 1'h0, data, 3'h2}), 38, 5);
		exp_q.push_back(1'h0);
		push_word(rtw_pkg::CFG_RESET);
		check_stream(90, 3'h5);
		// new config: max block 1, terminator, delay bit
		cmd(70'({2'h2, 1'h0, cfg, 3'h0}), 38, -1);
		exp_q.push_back(1'h0);
		push_word(cfg);
		check_stream(90, 3'h6);
		// reset opcode: reload, damped delay, terminated cycles of block 1
		cmd(70'(2'h0), 2, -1);
		repeat (260) @(posedge fclk);
		check_bit("delay damping", 1'h1, mod_load);
		exp_q.push_back(1'h0);
		push_term();
		push_word(data);
		push_term();
		push_word(data);
		check_stream(42, 3'h4);
		// password mode: store password in block 7, enable it, reload by reset opcode
		pw = $urandom();
		cmd(70'({2'h2, 1'h0, pw, 3'h7}), 38, -1);
		exp_q.push_back(1'h0);
		push_term();
		push_word(pw);
		check_stream(90, 3'h6);
		cmd(70'({2'h2, 1'h0, cfg | 32'h00000010, 3'h0}), 38, -1);
		exp_q.push_back(1'h0);
		push_term();
		push_word(cfg | 32'h00000010);
		check_stream(90, 3'h6);
		cmd(70'(2'h0), 2, -1);
		repeat (300) @(posedge fclk);
		// direct access with the right password reads block 1
		cmd(70'({2'h2, pw, 1'h0, 3'h1}), 38, -1);
		exp_q.push_back(1'h0);
		push_term();
		push_word(data);
		check_stream(90, 3'h6);
		// wrong password falls back to regular read
		cmd(70'({2'h2, ~pw, 1'h0, 3'h1}), 38, -1);
		exp_q.push_back(1'h0);
		push_term();
		push_word(data);
		check_stream(90, 3'h4);
		final_report();
	end
endmodule // rfid_tag_read_write_protocol_bench
`default_nettype wire
